/* reset_and_irq_flag_control.sv */
// Reset sequencer and interrupt request flag keeper with an AXI4-Lite register file.
// Assumes the pin and supply comparator are asynchronous, the core and watchdog share ref_clk.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "reset_ctl_regs.svh"

module reset_and_irq_flag_control #(
  parameter int NUM_IRQ   = 8,
  parameter int SEL_WIDTH = 2
) (
  // Clock and power-on reset
  input  wire logic                   ref_clk,
  input  wire logic                   arst_n,
  // Reset pin, supply comparator and configuration options
  input  wire logic                   extResetPinN,
  input  wire logic                   lowSupplyDet,
  input  wire logic                   lowSupplyOptEn,
  input  wire logic [SEL_WIDTH-1:0]   lowSupplyOptSel,
  output logic      [SEL_WIDTH-1:0]   lowSupplyThreshold,
  // Core status and watchdog
  input  wire logic                   watchdogOverflow,
  input  wire logic                   powerDown,
  input  wire logic                   stackFull,
  // Reset outputs to the core
  output logic                        coreResetN,
  output logic                        runEnable,
  output logic                        pcSpClear,
  output logic                        wakeUp,
  // Interrupt events and service handshake
  input  wire logic [NUM_IRQ-1:0]     irqEvent,
  input  wire logic                   fskFrameEvent,
  input  wire logic                   ringDetectEvent,
  input  wire logic                   carrierDetectEvent,
  input  wire logic                   irqAck,
  output logic                        irqRequest,
  output logic [$clog2(NUM_IRQ)-1:0]  irqIndex,
  output logic                        pushPc,
  // Port registers
  output logic [7:0]                  portData,
  output logic [7:0]                  portDir,
  // AXI4-Lite write channels
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [7:0]             s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp
);

  localparam int IW = $clog2(NUM_IRQ);
  localparam logic [11:0] EXTRA_CYC = 12'(`RESET_EXTRA_CYCLES);
  localparam logic [11:0] LOW_CYC   = 12'(`LOW_SUPPLY_CYCLES);

  // ****************************************************************
  // State of the block
  // ****************************************************************
  typedef struct packed {
    logic                      pinS1;
    logic                      pinS2;
    logic                      lowS1;
    logic                      lowS2;
    logic                      optTaken;
    logic                      optEn;
    logic [SEL_WIDTH-1:0]      optSel;
    logic [11:0]               lowCnt;
    logic [11:0]               delayCnt;
    reset_ctl_pkg::seq_state_t seq;
    logic                      partial;
    reset_ctl_pkg::reset_cause_t cause;
    logic                      timeout;
    logic                      coreRstN;
    logic                      run;
    logic                      pcSp;
    logic                      wake;
    logic [`CTRL_WIDTH-1:0]    ctrl;
    logic [NUM_IRQ-1:0]        irqEn;
    logic [NUM_IRQ-1:0]        flags;
    logic                      req;
    logic [IW-1:0]             idx;
    logic                      push;
    logic [7:0]                pData;
    logic [7:0]                pDir;
    logic                      awHeld;
    logic [7:0]                awAddr;
    logic                      wHeld;
    logic [31:0]               wData;
    logic [3:0]                wStrb;
    logic                      bValid;
    logic [1:0]                bResp;
    logic                      rValid;
    logic [31:0]               rData;
    logic [1:0]                rResp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Reset value of the whole state record.
  function automatic state_t resetState();
    state_t s;
    s          = '0;
    s.seq      = reset_ctl_pkg::SEQ_HOLD;
    s.cause    = '0;
    s.pData    = `PORT_RESET_VAL;
    s.pDir     = `PORT_RESET_VAL;
    return s;
  endfunction

  // Constant image of the reset state, so the reset branch loads a constant only.
  localparam state_t RESET_STATE = resetState();

  // Register read multiplexer.
  function automatic logic [31:0] readReg(input state_t s, input logic [7:0] a,
                                          output logic hit);
    logic [31:0] d;
    d   = '0;
    hit = 1'b1;
    if (a == `OFS_CTRL) begin
      d[`CTRL_WIDTH-1:0] = s.ctrl;
    end else if (a == `OFS_IRQ_ENABLE) begin
      d[NUM_IRQ-1:0] = s.irqEn;
    end else if (a == `OFS_IRQ_FLAGS) begin
      d[NUM_IRQ-1:0] = s.flags;
    end else if (a == `OFS_STATUS) begin
      d[`STAT_TIMEOUT] = s.timeout;
      d[`STAT_CAUSE_LSB +: 5] = s.cause;
      d[`STAT_OPT_EN] = s.optEn;
      d[`STAT_OPT_SEL +: SEL_WIDTH] = s.optSel;
    end else if (a == `OFS_PORT_DATA) begin
      d[7:0] = s.pData;
    end else if (a == `OFS_PORT_DIR) begin
      d[7:0] = s.pDir;
    end else begin
      hit = 1'b0;
    end
    return d;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic              pinLow;
    logic              lowValid;
    logic              wdtNormal;
    logic              wdtPd;
    logic              fullReq;
    logic [NUM_IRQ-1:0] setVec;
    logic [NUM_IRQ-1:0] clrVec;
    logic [NUM_IRQ-1:0] live;
    logic              hit;
    logic [31:0]       rd;
    pinLow    = 1'b0;
    lowValid  = 1'b0;
    wdtNormal = 1'b0;
    wdtPd     = 1'b0;
    fullReq   = 1'b0;
    setVec    = '0;
    clrVec    = '0;
    live      = '0;
    hit       = 1'b0;
    rd        = '0;
    st_nxt    = st_r;

    // Two-stage synchronisers for the pin and the comparator.
    st_nxt.pinS1 = extResetPinN;
    st_nxt.pinS2 = st_r.pinS1;
    st_nxt.lowS1 = lowSupplyDet;
    st_nxt.lowS2 = st_r.lowS1;

    // Configuration options are caught once after reset release.
    if (!st_r.optTaken) begin
      st_nxt.optTaken = 1'b1;
      st_nxt.optEn    = lowSupplyOptEn;
      st_nxt.optSel   = lowSupplyOptSel;
    end

    // Low supply must persist past the minimum before it counts.
    if (st_r.lowS2 && st_r.optEn && st_r.optTaken) begin
      if (st_r.lowCnt <= LOW_CYC) begin
        st_nxt.lowCnt = st_r.lowCnt + 12'h001;
      end
    end else begin
      st_nxt.lowCnt = '0;
    end
    lowValid  = st_r.lowCnt > LOW_CYC;
    pinLow    = !st_r.pinS2;
    wdtNormal = watchdogOverflow && !powerDown && st_r.run;
    wdtPd     = watchdogOverflow && powerDown && st_r.run;
    fullReq   = pinLow || lowValid || wdtNormal;

    // Reset sequencer.
    st_nxt.pcSp = 1'b0;
    case (st_r.seq)
      reset_ctl_pkg::SEQ_HOLD: begin
        st_nxt.coreRstN = 1'b0;
        st_nxt.run      = 1'b0;
        st_nxt.delayCnt = '0;
        if (!pinLow && !lowValid) begin
          st_nxt.seq = reset_ctl_pkg::SEQ_DELAY;
        end
      end
      reset_ctl_pkg::SEQ_DELAY: begin
        if (fullReq) begin
          st_nxt.seq      = reset_ctl_pkg::SEQ_HOLD;
          st_nxt.coreRstN = 1'b0;
          st_nxt.partial  = 1'b0;
          st_nxt.ctrl     = '0;
          st_nxt.irqEn    = '0;
          st_nxt.flags    = '0;
          st_nxt.pData    = `PORT_RESET_VAL;
          st_nxt.pDir     = `PORT_RESET_VAL;
        end else if (st_r.delayCnt >= EXTRA_CYC - 12'h001) begin
          st_nxt.seq      = reset_ctl_pkg::SEQ_RUN;
          st_nxt.coreRstN = 1'b1;
          st_nxt.run      = 1'b1;
          st_nxt.partial  = 1'b0;
        end else begin
          st_nxt.delayCnt = st_r.delayCnt + 12'h001;
        end
      end
      reset_ctl_pkg::SEQ_RUN: begin
        if (fullReq) begin
          st_nxt.seq      = reset_ctl_pkg::SEQ_HOLD;
          st_nxt.coreRstN = 1'b0;
          st_nxt.run      = 1'b0;
          st_nxt.cause    = '0;
          st_nxt.cause.pin       = pinLow;
          st_nxt.cause.lowSupply = lowValid && !pinLow;
          st_nxt.cause.wdtNormal = wdtNormal && !pinLow && !lowValid;
          if (wdtNormal) begin
            st_nxt.timeout = 1'b1;
          end
          st_nxt.ctrl  = '0;
          st_nxt.irqEn = '0;
          st_nxt.flags = '0;
          st_nxt.pData = `PORT_RESET_VAL;
          st_nxt.pDir  = `PORT_RESET_VAL;
        end else if (wdtPd) begin
          st_nxt.seq      = reset_ctl_pkg::SEQ_DELAY;
          st_nxt.run      = 1'b0;
          st_nxt.partial  = 1'b1;
          st_nxt.pcSp     = 1'b1;
          st_nxt.timeout  = 1'b1;
          st_nxt.delayCnt = '0;
          st_nxt.cause    = '0;
          st_nxt.cause.wdtPowerDown = 1'b1;
        end
      end
      default: begin
        st_nxt.seq = reset_ctl_pkg::SEQ_HOLD;
      end
    endcase

    // Interrupt flags: events set, service or software clears, set wins.
    setVec = irqEvent;
    if ((fskFrameEvent && st_r.ctrl[`CTRL_FRAME_MSK]) ||
        (ringDetectEvent && st_r.ctrl[`CTRL_RING_MSK]) ||
        (carrierDetectEvent && st_r.ctrl[`CTRL_CARR_MSK])) begin
      setVec[`IRQ_PERIPH_IDX] = setVec[`IRQ_PERIPH_IDX] || !st_r.ctrl[`CTRL_FSK_DATA];
    end
    st_nxt.push = 1'b0;
    if (irqAck && st_r.req && st_r.run) begin
      clrVec[st_r.idx] = 1'b1;
      st_nxt.ctrl[`CTRL_GLOBAL_EN] = 1'b0;
      st_nxt.push = 1'b1;
    end

    // Register writes once address and data are both held.
    if (st_r.awHeld && st_r.wHeld && !st_r.bValid) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = `RESP_OKAY;
      if (st_r.awAddr == `OFS_CTRL) begin
        if (st_r.wStrb[0]) st_nxt.ctrl = st_r.wData[`CTRL_WIDTH-1:0];
      end else if (st_r.awAddr == `OFS_IRQ_ENABLE) begin
        if (st_r.wStrb[0]) st_nxt.irqEn = st_r.wData[NUM_IRQ-1:0];
      end else if (st_r.awAddr == `OFS_IRQ_FLAGS) begin
        if (st_r.wStrb[0]) clrVec = clrVec | st_r.wData[NUM_IRQ-1:0];
      end else if (st_r.awAddr == `OFS_STATUS) begin
        st_nxt.bResp = `RESP_OKAY;
      end else if (st_r.awAddr == `OFS_PORT_DATA) begin
        if (st_r.wStrb[0]) st_nxt.pData = st_r.wData[7:0];
      end else if (st_r.awAddr == `OFS_PORT_DIR) begin
        if (st_r.wStrb[0]) st_nxt.pDir = st_r.wData[7:0];
      end else begin
        st_nxt.bResp = `RESP_SLVERR;
      end
    end
    if (st_r.run && !fullReq) begin
      st_nxt.flags = (st_r.flags & ~clrVec) | setVec;
    end

    // Request, priority index and wake-up from registered flags.
    live       = st_r.flags & st_r.irqEn;
    st_nxt.req = (|live) && st_r.ctrl[`CTRL_GLOBAL_EN] && !stackFull && st_r.run;
    st_nxt.idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (live[i]) st_nxt.idx = IW'(i);
    end
    st_nxt.wake = powerDown && (|st_r.flags);

    // AXI write channel acceptance, either order.
    if (s_axi_awvalid && !st_r.awHeld) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !st_r.wHeld) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end

    // AXI read channel.
    if (s_axi_arvalid && !st_r.rValid) begin
      rd = readReg(st_r, {s_axi_araddr[7:2], 2'b00}, hit);
      st_nxt.rValid = 1'b1;
      st_nxt.rData  = rd;
      st_nxt.rResp  = hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state record
  // ****************************************************************
  assign lowSupplyThreshold = st_r.optSel;
  assign coreResetN    = st_r.coreRstN;
  assign runEnable     = st_r.run;
  assign pcSpClear     = st_r.pcSp;
  assign wakeUp        = st_r.wake;
  assign irqRequest    = st_r.req;
  assign irqIndex      = st_r.idx;
  assign pushPc        = st_r.push;
  assign portData      = st_r.pData;
  assign portDir       = st_r.pDir;
  assign s_axi_awready = !st_r.awHeld;
  assign s_axi_wready  = !st_r.wHeld;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = !st_r.rValid;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;

endmodule

/* reset_ctl_regs.svh */
// Register offsets, reset values and timing figures of the reset and flag controller.
// Assumes a 100 MHz ref_clk and a 32-bit AXI4-Lite register bus.
`ifndef RESET_CTL_REGS_SVH
`define RESET_CTL_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_IRQ_ENABLE  8'h04
`define OFS_IRQ_FLAGS   8'h08
`define OFS_STATUS      8'h0C
`define OFS_PORT_DATA   8'h10
`define OFS_PORT_DIR    8'h14

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_GLOBAL_EN  0
`define CTRL_FSK_DATA   1
`define CTRL_FRAME_MSK  2
`define CTRL_RING_MSK   3
`define CTRL_CARR_MSK   4
`define CTRL_WIDTH      5

// ****************************************************************
// Status register fields
// ****************************************************************
`define STAT_TIMEOUT    0
`define STAT_CAUSE_LSB  1
`define STAT_OPT_EN     6
`define STAT_OPT_SEL    7

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define PORT_RESET_VAL  8'hFF
`define PC_RESET_VAL    16'h0000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define IRQ_PERIPH_IDX  3

// ****************************************************************
// Timing figures in ns and derived cycle counts
// ****************************************************************
`define CLK_PERIOD_NS        10
`define RESET_EXTRA_DELAY_NS 20000
`define LOW_SUPPLY_MIN_NS    1000
`define RESET_EXTRA_CYCLES   ((`RESET_EXTRA_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_SUPPLY_CYCLES    ((`LOW_SUPPLY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* reset_ctl_pkg.sv */
// Types shared by the reset and flag controller.
// Assumes reset_ctl_regs.svh supplies all numeric constants.
package reset_ctl_pkg;

  // Sequencer states: held in reset, counting the start-up delay, running.
  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_DELAY,
    SEQ_RUN
  } seq_state_t;

  // Reset cause, five source bits, at most one set; powerOn is never set, so power-on leaves all zero.
  typedef struct packed {
    logic wdtPowerDown;
    logic wdtNormal;
    logic lowSupply;
    logic pin;
    logic powerOn;
  } reset_cause_t;

endpackage

/* reset_ctl_assertions.sv */
// Concurrent checks on the ports of the reset sequencer and flag keeper.
// Assumes one ref_clk domain and reset_ctl_regs.svh on the include path.
`timescale 1ns/10ps
`include "reset_ctl_regs.svh"
module reset_ctl_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // Causes
  input wire logic       extResetPinN,
  input wire logic       watchdogOverflow,
  input wire logic       powerDown,
  input wire logic       irqAck,
  // Outputs watched
  input wire logic       coreResetN,
  input wire logic       runEnable,
  input wire logic       pcSpClear,
  input wire logic       wakeUp,
  input wire logic       irqRequest,
  input wire logic       pushPc,
  input wire logic [7:0] portData,
  input wire logic [7:0] portDir
);
  localparam int DelayCycles = `RESET_EXTRA_CYCLES;
  logic [11:0] holdCnt_r;

  // Counts the cycles for which execution is held off, saturating.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_r <= 12'h000;
    end else if (runEnable) begin
      holdCnt_r <= 12'h000;
    end else if (holdCnt_r != 12'hFFF) begin
      holdCnt_r <= holdCnt_r + 12'h001;
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_delay_len: assert property ($rose(runEnable) |-> int'(holdCnt_r) >= DelayCycles)
    else $error("execution resumed before the start-up delay ran out");
  chk_run_gated: assert property (!coreResetN |-> !runEnable)
    else $error("execution allowed while the core is in reset");
  chk_port_init: assert property ($fell(coreResetN) |-> portData == 8'hFF && portDir == 8'hFF)
    else $error("ports not set to inputs on reset");
  chk_pin_reset: assert property ($fell(extResetPinN) ##1 !extResetPinN [*3] |-> ##[0:4] !coreResetN)
    else $error("low reset pin did not reset the core");
  chk_wdt_run: assert property (watchdogOverflow && !powerDown && runEnable |-> ##[1:3] !coreResetN)
    else $error("watchdog overflow did not reset the core");
  chk_wdt_sleep: assert property (watchdogOverflow && powerDown && runEnable |=> pcSpClear && coreResetN)
    else $error("watchdog in power-down gave the wrong reset");
  chk_push_ack: assert property (irqAck && irqRequest && runEnable |=> pushPc)
    else $error("accepted service gave no counter push");
  chk_push_cause: assert property (pushPc |-> $past(irqAck && irqRequest))
    else $error("counter push without an accepted service");
  chk_wake_level: assert property (wakeUp |-> $past(powerDown))
    else $error("wake-up raised outside power-down");

  cover property ($rose(runEnable));
  cover property (pushPc);
  cover property (pcSpClear);
  cover property (wakeUp);
endmodule

bind reset_and_irq_flag_control reset_ctl_checker chk_u (
  .ref_clk(ref_clk), .arst_n(arst_n), .extResetPinN(extResetPinN),
  .watchdogOverflow(watchdogOverflow), .powerDown(powerDown), .irqAck(irqAck),
  .coreResetN(coreResetN), .runEnable(runEnable), .pcSpClear(pcSpClear),
  .wakeUp(wakeUp), .irqRequest(irqRequest), .pushPc(pushPc),
  .portData(portData), .portDir(portDir)
);

/* reset_supply_model.sv */
// Model of the external reset circuit and the supply comparator.
// Assumes the bench calls drive() just after a rising edge of ref_clk.
`timescale 1ns/10ps
module reset_supply_model (
  // Clock
  input  wire logic ref_clk,
  // Reset pin and comparator
  output logic      extResetPinN,
  output logic      lowSupplyDet
);
  // The pin rests high through its pull-up and the supply starts healthy.
  initial begin
    extResetPinN = 1'b1;
    lowSupplyDet = 1'b0;
  end

  // Sets pin and comparator levels at the next rising edge.
  task automatic drive(input logic pinLevel, input logic lowLevel);
    @(posedge ref_clk);
    extResetPinN <= pinLevel;
    lowSupplyDet <= lowLevel;
  endtask
endmodule

/* tb.sv */
// Self-checking bench: AXI4-Lite register tasks and reset and interrupt sequences.
// Assumes the design, its header, the checker and the supply model compile first.
`timescale 1ns/10ps
`include "reset_ctl_regs.svh"
module tb;
  // ********************
  // Signals
  // ********************
  logic        ref_clk, arst_n, optEn, wdt, pd, ack, pinN, lowDet;
  logic        coreResetN, runEnable, pcSpClear, wakeUp, irqRequest, pushPc;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  optSel, thr, bresp, rresp;
  logic [2:0]  subEv, irqIndex;
  logic [7:0]  irqEv, portData, portDir, awaddr, araddr;
  logic [31:0] wdata, rdata;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  localparam logic [1:0]  OkResp = `RESP_OKAY;
  localparam logic [31:0] OptBits = (32'h1 << `STAT_OPT_EN) | (32'h2 << `STAT_OPT_SEL);
  localparam logic [31:0] ToBit = 32'h1 << `STAT_TIMEOUT;

  reset_supply_model supply_u (.ref_clk(ref_clk), .extResetPinN(pinN), .lowSupplyDet(lowDet));

  reset_and_irq_flag_control dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .extResetPinN(pinN), .lowSupplyDet(lowDet),
    .lowSupplyOptEn(optEn), .lowSupplyOptSel(optSel), .lowSupplyThreshold(thr),
    .watchdogOverflow(wdt), .powerDown(pd), .stackFull(1'b0), .coreResetN(coreResetN),
    .runEnable(runEnable), .pcSpClear(pcSpClear), .wakeUp(wakeUp), .irqEvent(irqEv),
    .fskFrameEvent(subEv[0]), .ringDetectEvent(subEv[1]), .carrierDetectEvent(subEv[2]),
    .irqAck(ack), .irqRequest(irqRequest), .irqIndex(irqIndex), .pushPc(pushPc),
    .portData(portData), .portDir(portDir), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp)
  );

  // ********************
  // Tasks
  // ********************
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One write: address and data offered together, each released when taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge ref_clk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge ref_clk);
    bready <= 1'b0;
    check(bresp, er);
  endtask

  // One read, compared with the expected data and response.
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge ref_clk);
    rready <= 1'b0;
    check(rdata, ed);
    check(rresp, er);
  endtask

  // One-cycle event pulses on the flag inputs.
  task automatic pulse(input logic [7:0] ev, input logic [2:0] sv);
    @(posedge ref_clk);
    irqEv <= ev;
    subEv <= sv;
    @(posedge ref_clk);
    irqEv <= 8'h00;
    subEv <= 3'h0;
  endtask

  // Counts cycles until execution is allowed and checks the start-up delay.
  task automatic waitRun();
    int n;
    n = 0;
    while (runEnable !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    check(n >= `RESET_EXTRA_CYCLES && n <= `RESET_EXTRA_CYCLES + 10, 1'b1);
  endtask

  function automatic logic [31:0] cause(input int k);
    return 32'h1 << (`STAT_CAUSE_LSB + k);
  endfunction

  // ********************
  // Clock and timeout
  // ********************
  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Cuts a hang short.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      results();
    end
  end

  // ********************
  // Main sequence
  // ********************
  // Power-on, registers, flags, then each reset source in turn.
  initial begin
    arst_n = 1'b0; optEn = 1'b1; optSel = 2'h2; wdt = 1'b0; pd = 1'b0; ack = 1'b0;
    subEv = 3'h0; irqEv = 8'h00; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    repeat (6) @(posedge ref_clk);
    check(portData, 8'hFF);
    check(portDir, 8'hFF);
    check(coreResetN, 1'b0);
    arst_n <= 1'b1;
    waitRun();
    check(thr, 2'h2);
    axr(`OFS_STATUS, OptBits, OkResp);
    axr(8'h20, 32'h0, `RESP_SLVERR);
    axw(`OFS_STATUS, 32'hFF, OkResp);
    axr(`OFS_STATUS, OptBits, OkResp);
    axw(`OFS_PORT_DIR, 32'h0F, OkResp);
    check(portDir, 8'h0F);
    pulse(8'h20, 3'h0);
    repeat (3) @(posedge ref_clk);
    check(irqRequest, 1'b0);
    axr(`OFS_IRQ_FLAGS, 32'h20, OkResp);
    pd <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(wakeUp, 1'b1);
    pd <= 1'b0;
    axw(`OFS_IRQ_FLAGS, 32'h20, OkResp);
    axr(`OFS_IRQ_FLAGS, 32'h0, OkResp);
    axw(`OFS_IRQ_ENABLE, 32'h04, OkResp);
    axw(`OFS_CTRL, 32'h01, OkResp);
    pulse(8'h04, 3'h0);
    for (int i = 0; i < 20 && irqRequest !== 1'b1; i++) @(posedge ref_clk);
    check(irqIndex, 3'h2);
    // The service routine makes no nested call and saves its own context.
    ack <= 1'b1;
    @(posedge ref_clk);
    ack <= 1'b0;
    @(posedge ref_clk);
    check(pushPc, 1'b1);
    axr(`OFS_CTRL, 32'h0, OkResp);
    axr(`OFS_IRQ_FLAGS, 32'h0, OkResp);
    for (int i = 0; i < 3; i++) begin
      axw(`OFS_CTRL, (32'h4 << i) | 32'h2, OkResp);
      pulse(8'h00, 3'h1 << i);
      axr(`OFS_IRQ_FLAGS, 32'h0, OkResp);
      axw(`OFS_CTRL, 32'h4 << i, OkResp);
      pulse(8'h00, 3'h1 << i);
      axr(`OFS_IRQ_FLAGS, 32'h1 << `IRQ_PERIPH_IDX, OkResp);
      axw(`OFS_IRQ_FLAGS, 32'h1 << `IRQ_PERIPH_IDX, OkResp);
    end
    supply_u.drive(1'b1, 1'b1);
    repeat (50) @(posedge ref_clk);
    supply_u.drive(1'b1, 1'b0);
    repeat (10) @(posedge ref_clk);
    check({coreResetN, runEnable}, 2'h3);
    axw(`OFS_PORT_DATA, 32'h5A, OkResp);
    check(portData, 8'h5A);
    supply_u.drive(1'b1, 1'b1);
    repeat (150) @(posedge ref_clk);
    check(coreResetN, 1'b0);
    check({portData, portDir}, 16'hFFFF);
    supply_u.drive(1'b1, 1'b0);
    waitRun();
    axr(`OFS_STATUS, OptBits | cause(2), OkResp);
    axw(`OFS_CTRL, 32'h01, OkResp);
    supply_u.drive(1'b0, 1'b0);
    repeat (20) @(posedge ref_clk);
    check(coreResetN, 1'b0);
    supply_u.drive(1'b1, 1'b0);
    waitRun();
    axr(`OFS_STATUS, OptBits | cause(1), OkResp);
    axr(`OFS_CTRL, 32'h0, OkResp);
    @(posedge ref_clk);
    wdt <= 1'b1;
    @(posedge ref_clk);
    wdt <= 1'b0;
    @(posedge ref_clk);
    check(coreResetN, 1'b0);
    waitRun();
    axr(`OFS_STATUS, OptBits | ToBit | cause(3), OkResp);
    axw(`OFS_PORT_DATA, 32'h3C, OkResp);
    pd <= 1'b1;
    @(posedge ref_clk);
    wdt <= 1'b1;
    @(posedge ref_clk);
    wdt <= 1'b0;
    @(posedge ref_clk);
    check({pcSpClear, coreResetN, runEnable}, 3'h6);
    waitRun();
    pd <= 1'b0;
    check(portData, 8'h3C);
    axr(`OFS_STATUS, OptBits | ToBit | cause(4), OkResp);
    results();
  end
endmodule
